// >>> hdl/acl_consts.vh
/*
 * Constants of the AC-link channel controller: register byte offsets,
 * field positions, slot geometry, channel codes and sample width codes.
 * Included by the controller, the monitor and the testbench; definitions only.
 */
`ifndef ACL_CONSTS_VH
`define ACL_CONSTS_VH

// ==================================================================
// register byte offsets
`define ACL_OFF_MODE        8'h08
`define ACL_OFF_IN_ASSIGN   8'h10
`define ACL_OFF_OUT_ASSIGN  8'h14
`define ACL_OFF_A_RX        8'h20
`define ACL_OFF_A_TX        8'h24
`define ACL_OFF_A_STAT      8'h28
`define ACL_OFF_A_MODE      8'h2C
`define ACL_OFF_B_RX        8'h30
`define ACL_OFF_B_TX        8'h34
`define ACL_OFF_B_STAT      8'h38
`define ACL_OFF_B_MODE      8'h3C
`define ACL_OFF_COD_RX      8'h40
`define ACL_OFF_COD_TX      8'h44
`define ACL_OFF_GSTAT       8'h50
`define ACL_OFF_IRQ_EN      8'h54
`define ACL_OFF_IRQ_DIS     8'h58
`define ACL_OFF_IRQ_MASK    8'h5C

// ==================================================================
// channel mode register fields
`define ACL_CM_SIZE_LO      0
`define ACL_CM_SIZE_HI      1
`define ACL_CM_ORDER        2
`define ACL_CM_ON           3
`define ACL_CM_IRQ          4
`define ACL_CM_RESET        5'h00

// sample width codes
`define ACL_SZ_20           2'h0
`define ACL_SZ_18           2'h1
`define ACL_SZ_16           2'h2
`define ACL_SZ_10           2'h3
`define ACL_MASK_20         20'hFFFFF
`define ACL_MASK_18         20'h3FFFF
`define ACL_MASK_16         20'h0FFFF
`define ACL_MASK_10         20'h003FF

// codec command register fields
`define ACL_CC_READ         23
`define ACL_CC_IDX_HI       22
`define ACL_CC_IDX_LO       16

// ==================================================================
// slot geometry
`define ACL_TAG_BITS        5'h10
`define ACL_SLOT_BITS       5'h14
`define ACL_LAST_SLOT       4'hC
`define ACL_CMD_SLOT        4'h1
`define ACL_DATA_SLOT       4'h2
`define ACL_FIRST_DSLOT     4'h3
`define ACL_TAG_MSB         4'hF
`define ACL_CODEC_ID        2'h0

// channel assignment codes, two bits per slot from slot 3 upward
`define ACL_CH_NONE         2'h0
`define ACL_CH_A            2'h1
`define ACL_CH_B            2'h2

// global status bit positions, shared by the mask registers
`define ACL_GS_COD_TX       0
`define ACL_GS_COD_RX       1
`define ACL_GS_EV_A         2
`define ACL_GS_EV_B         3
`endif

// >>> hdl/acl_controller.v
/*
 * AC-link channel controller: codec control channel on slots 1 and 2,
 * data channels A and B on slots 3 to 12, tag generation, sample width
 * and byte order handling, status flags and masked interrupt.
 * Assumes bit_clk and sdata_in come from the codec, far slower than
 * sys_clk (at least four sys_clk periods per bit_clk half period),
 * and a register master on sys_clk using one-cycle strobes.
 */
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`include "acl_consts.vh"

// Operation
// - codec channel alone uses slots 1 and 2 outgoing, slot 2 incoming
// - slots 3 to 12 go to channel A or B by input/output assignment
// - data slots may be unassigned; slots 0 to 2 never assignable
// - samples 10, 16, 18 or 20 bits wide, carried in 20-bit slots
// - only channel A has the DMA request/acknowledge ports
// - every slot shifted out most significant bit first
// - per data channel big-endian reordering when byte order bit set
// - transmit-ready set when holding moves to shift register
// - transmit-empty set when all requested words were shifted out
// - thirteen-slot frame, tag marks frame and slot validity
// - assigned slots valid only with pending data, else tag invalid
// - received slot goes to holding, sets ready; status read clears
// - unread holding overwritten by new data and overrun raised
// - unassigned incoming data slots captured nowhere
// - interrupt when status and mask agree; enable/disable set/clear mask
// - tag: frame bit, twelve slot bits, two codec id bits
// - slot 1: read/write bit, seven-bit index, reserved zeros
// - slot 2: data in bits 19 to 4, all zero for a read
module acl_controller (
    input  wire        sys_clk,
    input  wire        resetn,
    input  wire [7:0]  addr,
    input  wire [31:0] wr_data,
    input  wire        wr_strobe,
    input  wire        rd_strobe,
    output reg  [31:0] rd_data,
    input  wire        bit_clk,
    input  wire        sdata_in,
    output reg         ac_sync,
    output reg         sdata_out,
    output wire        irq,
    output wire        dma_tx_req,
    input  wire        dma_tx_wr,
    input  wire [31:0] dma_tx_data,
    output wire        dma_rx_req,
    input  wire        dma_rx_ack,
    output wire [31:0] dma_rx_data
);

    // ==============================================================
    // functions
    function [1:0] chan_of;
        input [19:0] asg;
        input [3:0]  s;
        reg   [4:0]  base;
        begin
            base = 5'h00;
            if (s < `ACL_FIRST_DSLOT || s > `ACL_LAST_SLOT) begin
                chan_of = `ACL_CH_NONE;
            end else begin
                base = {s - `ACL_FIRST_DSLOT, 1'b0};
                chan_of = asg[base +: 2];
            end
        end
    endfunction

    function [19:0] width_mask;
        input [1:0] sz;
        begin
            case (sz)
                `ACL_SZ_20: width_mask = `ACL_MASK_20;
                `ACL_SZ_18: width_mask = `ACL_MASK_18;
                `ACL_SZ_16: width_mask = `ACL_MASK_16;
                default:    width_mask = `ACL_MASK_10;
            endcase
        end
    endfunction

    function [19:0] fmt_tx;
        input [31:0] r;
        input [1:0]  sz;
        input        be;
        reg   [19:0] w;
        begin
            w = r[19:0];
            if (be) begin
                if (sz == `ACL_SZ_20 || sz == `ACL_SZ_18)
                    w = {r[11:8], r[23:16], r[31:24]};
                else
                    w = {4'h0, r[7:0], r[15:8]};
            end
            fmt_tx = w & width_mask(sz);
        end
    endfunction

    function [31:0] fmt_rx;
        input [19:0] w;
        input [1:0]  sz;
        input        be;
        reg   [19:0] d;
        begin
            d = w & width_mask(sz);
            if (!be)
                fmt_rx = {12'h000, d};
            else if (sz == `ACL_SZ_20 || sz == `ACL_SZ_18)
                fmt_rx = {d[7:0], d[15:8], 4'h0, d[19:16], 8'h00};
            else
                fmt_rx = {16'h0000, d[7:0], d[15:8]};
        end
    endfunction

    function [4:0] slot_len;
        input [3:0] s;
        begin
            slot_len = (s == 4'h0) ? `ACL_TAG_BITS : `ACL_SLOT_BITS;
        end
    endfunction

    // ==============================================================
    // state
    reg         function_on;
    reg  [19:0] input_slot_assignment;
    reg  [19:0] output_slot_assignment;
    reg  [4:0]  chan_mode_reg [0:1];
    reg  [31:0] thr           [0:1];
    reg  [31:0] shw           [0:1];
    reg  [31:0] rhr           [0:1];
    reg  [1:0]  thr_full;
    reg  [1:0]  sh_full;
    reg  [1:0]  sending;
    reg  [1:0]  receive_word_available;
    reg  [1:0]  receive_overwrite_flag;
    reg  [23:0] cod_cmd;
    reg         cod_pend;
    reg  [15:0] cod_rx;
    reg         cod_rx_rdy;
    reg  [3:0]  irq_mask_reg;
    reg  [2:0]  bclk_s;
    reg  [1:0]  din_s;
    reg  [3:0]  slot;
    reg  [4:0]  bis;
    reg  [3:0]  in_slot;
    reg  [4:0]  in_bis;
    reg  [19:0] out_sh;
    reg  [19:0] in_sh;
    reg  [15:0] tag_reg;
    reg  [15:0] in_tag;

    wire        rise = bclk_s[1] & ~bclk_s[2];
    wire        fall = ~bclk_s[1] & bclk_s[2];
    wire        din  = din_s[1];
    wire [1:0]  chon = {chan_mode_reg[1][`ACL_CM_ON], chan_mode_reg[0][`ACL_CM_ON]};
    wire [1:0]  transmit_holding_free = ~thr_full;
    wire [1:0]  transmit_all_shifted  = ~thr_full & ~sh_full & ~sending;
    wire [3:0]  stat_a = {receive_overwrite_flag[0], receive_word_available[0],
                          transmit_all_shifted[0], transmit_holding_free[0]};
    wire [3:0]  stat_b = {receive_overwrite_flag[1], receive_word_available[1],
                          transmit_all_shifted[1], transmit_holding_free[1]};
    wire [3:0]  global_status_reg = {chan_mode_reg[1][`ACL_CM_IRQ] & (|stat_b),
                                     chan_mode_reg[0][`ACL_CM_IRQ] & (|stat_a),
                                     cod_rx_rdy, ~cod_pend};
    wire        rd_stat_a = rd_strobe && addr == `ACL_OFF_A_STAT;
    wire        rd_stat_b = rd_strobe && addr == `ACL_OFF_B_STAT;
    wire        wr_tx_a   = (wr_strobe && addr == `ACL_OFF_A_TX) || dma_tx_wr;
    wire        wr_tx_b   = wr_strobe && addr == `ACL_OFF_B_TX;

    assign irq         = |(global_status_reg & irq_mask_reg);
    assign dma_tx_req  = chon[0] & ~thr_full[0];
    assign dma_rx_req  = receive_word_available[0];
    assign dma_rx_data = rhr[0];

    // ==============================================================
    // tag of the next frame and slot ownership
    reg  [15:0] next_tag;
    reg  [1:0]  next_cnt_a;
    reg  [1:0]  next_cnt_b;
    reg  [1:0]  avail_a;
    reg  [1:0]  avail_b;
    reg  [1:0]  own;
    reg  [1:0]  consume;
    reg  [19:0] next_word;
    integer     si;

    always @* begin
        avail_a = chon[0] ? {1'b0, thr_full[0]} + {1'b0, sh_full[0]} : 2'h0;
        avail_b = chon[1] ? {1'b0, thr_full[1]} + {1'b0, sh_full[1]} : 2'h0;
        next_cnt_a = 2'h0;
        next_cnt_b = 2'h0;
        next_tag = 16'h0000;
        next_tag[`ACL_TAG_MSB - `ACL_CMD_SLOT] = cod_pend;
        next_tag[`ACL_TAG_MSB - `ACL_DATA_SLOT] = cod_pend & ~cod_cmd[`ACL_CC_READ];
        for (si = `ACL_FIRST_DSLOT; si <= `ACL_LAST_SLOT; si = si + 1) begin
            own = chan_of(output_slot_assignment, si[3:0]);
            if (own == `ACL_CH_A && next_cnt_a < avail_a) begin
                next_tag[`ACL_TAG_MSB - si[3:0]] = 1'b1;
                next_cnt_a = next_cnt_a + 2'h1;
            end else if (own == `ACL_CH_B && next_cnt_b < avail_b) begin
                next_tag[`ACL_TAG_MSB - si[3:0]] = 1'b1;
                next_cnt_b = next_cnt_b + 2'h1;
            end
        end
        next_tag[`ACL_TAG_MSB] = |next_tag[14:3];
        next_tag[1:0] = `ACL_CODEC_ID;
        own = chan_of(output_slot_assignment, slot);
        consume[0] = bis == 5'h00 && tag_reg[`ACL_TAG_MSB - slot] && own == `ACL_CH_A;
        consume[1] = bis == 5'h00 && tag_reg[`ACL_TAG_MSB - slot] && own == `ACL_CH_B;
        case (slot)
            4'h0:           next_word = {next_tag, 4'h0};
            // codec slots follow the tag already sent, not a command queued after it
            `ACL_CMD_SLOT:  next_word = tag_reg[`ACL_TAG_MSB - `ACL_CMD_SLOT] ? {cod_cmd[`ACL_CC_READ],
                                cod_cmd[`ACL_CC_IDX_HI:`ACL_CC_IDX_LO], 12'h000} : 20'h00000;
            `ACL_DATA_SLOT: next_word = tag_reg[`ACL_TAG_MSB - `ACL_DATA_SLOT] ?
                                {cod_cmd[15:0], 4'h0} : 20'h00000;
            default: begin
                if (consume[0])
                    next_word = fmt_tx(shw[0], chan_mode_reg[0][`ACL_CM_SIZE_HI:`ACL_CM_SIZE_LO],
                                       chan_mode_reg[0][`ACL_CM_ORDER]);
                else if (consume[1])
                    next_word = fmt_tx(shw[1], chan_mode_reg[1][`ACL_CM_SIZE_HI:`ACL_CM_SIZE_LO],
                                       chan_mode_reg[1][`ACL_CM_ORDER]);
                else
                    next_word = 20'h00000;
            end
        endcase
    end

    // ==============================================================
    // registers, link and channel state
    wire [19:0] in_word = {in_sh[18:0], din};
    wire        in_last = in_bis == slot_len(in_slot) - 5'h01;
    wire        slot_go = rise && function_on && bis == 5'h00;
    integer     c;

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rd_data <= 32'h00000000;
            function_on <= 1'b0;
            input_slot_assignment <= 20'h00000;
            output_slot_assignment <= 20'h00000;
            for (c = 0; c < 2; c = c + 1) begin
                chan_mode_reg[c] <= `ACL_CM_RESET;
                thr[c] <= 32'h00000000;
                shw[c] <= 32'h00000000;
                rhr[c] <= 32'h00000000;
            end
            thr_full <= 2'h0;
            sh_full <= 2'h0;
            sending <= 2'h0;
            receive_word_available <= 2'h0;
            receive_overwrite_flag <= 2'h0;
            cod_cmd <= 24'h000000;
            cod_pend <= 1'b0;
            cod_rx <= 16'h0000;
            cod_rx_rdy <= 1'b0;
            irq_mask_reg <= 4'h0;
            bclk_s <= 3'h0;
            din_s <= 2'h0;
            slot <= 4'h0;
            bis <= 5'h00;
            in_slot <= 4'h0;
            in_bis <= 5'h00;
            out_sh <= 20'h00000;
            in_sh <= 20'h00000;
            tag_reg <= 16'h0000;
            in_tag <= 16'h0000;
            ac_sync <= 1'b0;
            sdata_out <= 1'b0;
        end else begin
            bclk_s <= {bclk_s[1:0], bit_clk};
            din_s <= {din_s[0], sdata_in};
            // register reads, data one cycle after the strobe
            if (rd_strobe) begin
                case (addr)
                    `ACL_OFF_MODE:       rd_data <= {31'h0, function_on};
                    `ACL_OFF_IN_ASSIGN:  rd_data <= {12'h000, input_slot_assignment};
                    `ACL_OFF_OUT_ASSIGN: rd_data <= {12'h000, output_slot_assignment};
                    `ACL_OFF_A_RX:       rd_data <= rhr[0];
                    `ACL_OFF_A_STAT:     rd_data <= {28'h0, stat_a};
                    `ACL_OFF_A_MODE:     rd_data <= {27'h0, chan_mode_reg[0]};
                    `ACL_OFF_B_RX:       rd_data <= rhr[1];
                    `ACL_OFF_B_STAT:     rd_data <= {28'h0, stat_b};
                    `ACL_OFF_B_MODE:     rd_data <= {27'h0, chan_mode_reg[1]};
                    `ACL_OFF_COD_RX:     rd_data <= {16'h0000, cod_rx};
                    `ACL_OFF_COD_TX:     rd_data <= {8'h00, cod_cmd};
                    `ACL_OFF_GSTAT:      rd_data <= {28'h0, global_status_reg};
                    `ACL_OFF_IRQ_MASK:   rd_data <= {28'h0, irq_mask_reg};
                    default:             rd_data <= 32'h00000000;
                endcase
            end
            // status reads clear receive flags; a capture below wins
            if (rd_stat_a || dma_rx_ack)
                receive_word_available[0] <= 1'b0;
            if (rd_stat_a)
                receive_overwrite_flag[0] <= 1'b0;
            if (rd_stat_b) begin
                receive_word_available[1] <= 1'b0;
                receive_overwrite_flag[1] <= 1'b0;
            end
            if (rd_strobe && addr == `ACL_OFF_COD_RX)
                cod_rx_rdy <= 1'b0;
            if (wr_strobe) begin
                case (addr)
                    `ACL_OFF_MODE:       function_on <= wr_data[0];
                    `ACL_OFF_IN_ASSIGN:  input_slot_assignment <= wr_data[19:0];
                    `ACL_OFF_OUT_ASSIGN: output_slot_assignment <= wr_data[19:0];
                    `ACL_OFF_A_MODE:     chan_mode_reg[0] <= wr_data[4:0];
                    `ACL_OFF_B_MODE:     chan_mode_reg[1] <= wr_data[4:0];
                    `ACL_OFF_IRQ_EN:     irq_mask_reg <= irq_mask_reg | wr_data[3:0];
                    `ACL_OFF_IRQ_DIS:    irq_mask_reg <= irq_mask_reg & ~wr_data[3:0];
                    default: ;
                endcase
            end
            // transmit path: holding to shift, slot consumption
            for (c = 0; c < 2; c = c + 1) begin
                if (slot_go && consume[c])
                    sh_full[c] <= 1'b0;
                else if (thr_full[c] && !sh_full[c]) begin
                    shw[c] <= thr[c];
                    sh_full[c] <= 1'b1;
                    thr_full[c] <= 1'b0;
                end
                if (slot_go)
                    sending[c] <= consume[c];
            end
            if (wr_tx_a) begin
                thr[0] <= dma_tx_wr ? dma_tx_data : wr_data;
                thr_full[0] <= 1'b1;
            end
            if (wr_tx_b) begin
                thr[1] <= wr_data;
                thr_full[1] <= 1'b1;
            end
            // only a command announced in this frame's tag has left
            if (slot_go && slot == `ACL_DATA_SLOT && tag_reg[`ACL_TAG_MSB - `ACL_CMD_SLOT])
                cod_pend <= 1'b0;
            if (wr_strobe && addr == `ACL_OFF_COD_TX) begin
                cod_cmd <= wr_data[23:0];
                cod_pend <= 1'b1;
            end
            // outgoing frame on bit clock rising edges
            if (!function_on) begin
                slot <= 4'h0;
                bis <= 5'h00;
                ac_sync <= 1'b0;
                sdata_out <= 1'b0;
            end else if (rise) begin
                if (bis == 5'h00) begin
                    sdata_out <= next_word[19];
                    out_sh <= {next_word[18:0], 1'b0};
                    if (slot == 4'h0)
                        tag_reg <= next_tag;
                end else begin
                    sdata_out <= out_sh[19];
                    out_sh <= {out_sh[18:0], 1'b0};
                end
                ac_sync <= slot == 4'h0;
                in_slot <= slot;
                in_bis <= bis;
                if (bis == slot_len(slot) - 5'h01) begin
                    bis <= 5'h00;
                    slot <= (slot == `ACL_LAST_SLOT) ? 4'h0 : slot + 4'h1;
                end else begin
                    bis <= bis + 5'h01;
                end
            end
            // incoming frame on bit clock falling edges
            if (function_on && fall) begin
                in_sh <= in_word;
                if (in_last) begin
                    if (in_slot == 4'h0)
                        in_tag <= in_word[15:0];
                    else if (in_slot == `ACL_DATA_SLOT && in_tag[`ACL_TAG_MSB - `ACL_DATA_SLOT]) begin
                        cod_rx <= in_word[19:4];
                        cod_rx_rdy <= 1'b1;
                    end
                    for (c = 0; c < 2; c = c + 1) begin
                        if (chon[c] && in_tag[`ACL_TAG_MSB - in_slot] &&
                            chan_of(input_slot_assignment, in_slot) == c[1:0] + 2'h1) begin
                            rhr[c] <= fmt_rx(in_word, chan_mode_reg[c][`ACL_CM_SIZE_HI:`ACL_CM_SIZE_LO],
                                             chan_mode_reg[c][`ACL_CM_ORDER]);
                            receive_word_available[c] <= 1'b1;
                            if (receive_word_available[c] && !(c == 0 ? (rd_stat_a || dma_rx_ack) : rd_stat_b))
                                receive_overwrite_flag[c] <= 1'b1;
                        end
                    end
                end
            end
        end
    end

endmodule

// >>> testbench/acl_codec_model.sv
/* behavioural codec at the far end of the AC-link.
   free-running bit clock; locks its frame count to the sync it sees. */
`timescale 1ns/100ps
module acl_codec_model (
    output logic        bit_clk,
    output logic        sdata_in,
    input  wire         ac_sync,
    input  wire         sdata_out,
    output logic [15:0] tag_seen,
    output logic [19:0] slot_seen [1:4]
);
    localparam logic [15:0] IN_TAG = 16'hFFF8;
    logic [7:0]  idx;
    logic [7:0]  cur;
    logic [19:0] sh;
    logic        sync_q;
    logic        lock;
    // ==========================================
    // incoming frame: tag, then slot k carries 9000k
    function automatic logic in_bit(input logic [7:0] b);
        logic [4:0]  k;
        logic [4:0]  p;
        logic [19:0] w;
        if (b < 8'h10)
            return IN_TAG[4'hF - b[3:0]];
        k = 5'((b - 8'h10) / 8'h14) + 5'h01;
        p = 5'((b - 8'h10) % 8'h14);
        w = {4'h9, 12'h000, k[3:0]};
        return w[5'h13 - p];
    endfunction
    initial begin
        bit_clk = 1'b0;
        forever #80 bit_clk = ~bit_clk;
    end
    initial begin
        sdata_in = 1'b0;
        idx = 8'h00;
        lock = 1'b0;
        sync_q = 1'b0;
    end
    // launch on the rise, the controller samples on the fall
    always @(posedge bit_clk)
        sdata_in <= lock ? in_bit(idx) : 1'b0;
    always @(negedge bit_clk) begin
        cur = (ac_sync && !sync_q) ? 8'h00 : idx;
        sync_q <= ac_sync;
        if (ac_sync && !sync_q)
            lock <= 1'b1;
        idx <= cur + 8'h01;
        sh <= {sh[18:0], sdata_out};
        if (cur == 8'h0F)
            tag_seen <= {sh[14:0], sdata_out};
        if (cur >= 8'h23 && cur <= 8'h5F && (cur - 8'h0F) % 8'h14 == 8'h00)
            slot_seen[(cur - 8'h0F) / 8'h14] <= {sh[18:0], sdata_out};
    end
endmodule

// >>> testbench/acl_monitor.sv
/* port checker of the AC-link channel controller.
   assumes the sys_clk domain and a bit clock far slower than it. */
`timescale 1ns/100ps
`include "acl_consts.vh"
module acl_monitor (
    input wire        sys_clk,
    input wire        resetn,
    input wire [7:0]  addr,
    input wire [31:0] wr_data,
    input wire        wr_strobe,
    input wire        rd_strobe,
    input wire [31:0] rd_data,
    input wire        bit_clk,
    input wire        ac_sync,
    input wire        sdata_out,
    input wire        irq,
    input wire        dma_tx_req,
    input wire        dma_tx_wr,
    input wire        dma_rx_req,
    input wire        dma_rx_ack
);
    logic [7:0]  hi_cnt;
    logic [11:0] fr_cnt;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // ==========================================
    // sync width and frame length counters
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            hi_cnt <= 8'h00;
            fr_cnt <= 12'h000;
        end else begin
            hi_cnt <= ac_sync ? hi_cnt + 8'h01 : 8'h00;
            if ($rose(ac_sync))
                fr_cnt <= 12'h001;
            else if (fr_cnt != 12'h000)
                fr_cnt <= fr_cnt + 12'h001;
        end
    end
    // ==========================================
    // assertions
    sync_width_a: assert property ($fell(ac_sync) |-> hi_cnt >= 8'h7F && hi_cnt <= 8'h81)
        else $error("sync high time wrong");
    frame_len_a: assert property ($rose(ac_sync) && fr_cnt != 12'h000 |-> fr_cnt >= 12'h7FF && fr_cnt <= 12'h801)
        else $error("frame length wrong");
    link_edge_a: assert property ($changed(sdata_out) || $changed(ac_sync) |-> $past(bit_clk, 2))
        else $error("link output moved off a bit clock rise");
    tx_take_a: assert property (dma_tx_wr |=> !dma_tx_req)
        else $error("transmit request stayed up after a load");
    rx_ack_a: assert property (dma_rx_ack |=> !dma_rx_req)
        else $error("receive request stayed up after ack");
    stat_clear_a: assert property (rd_strobe && addr == `ACL_OFF_A_STAT |=> !dma_rx_req)
        else $error("status read left receive ready");
    irq_off_a: assert property (wr_strobe && addr == `ACL_OFF_IRQ_DIS && wr_data[3:0] == 4'hF |=> !irq)
        else $error("interrupt up with all sources masked");
    mask_read_a: assert property (wr_strobe && addr == `ACL_OFF_IRQ_DIS && wr_data[3:0] == 4'hF ##2
        rd_strobe && addr == `ACL_OFF_IRQ_MASK |=> rd_data == 32'h0)
        else $error("mask not cleared by disable");
endmodule

bind acl_controller acl_monitor i_acl_monitor (.sys_clk(sys_clk), .resetn(resetn), .addr(addr),
    .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data), .bit_clk(bit_clk),
    .ac_sync(ac_sync), .sdata_out(sdata_out), .irq(irq), .dma_tx_req(dma_tx_req), .dma_tx_wr(dma_tx_wr),
    .dma_rx_req(dma_rx_req), .dma_rx_ack(dma_rx_ack));

// >>> testbench/test_ac_link_channel_controller.sv
/* testbench of the AC-link channel controller with a codec model.
   register access on sys_clk; checker bound to the controller. */
`timescale 1ns/100ps
`include "acl_consts.vh"
module test_ac_link_channel_controller;
    logic        sys_clk, resetn, wr_strobe, rd_strobe, bit_clk, sdata_in, ac_sync, sdata_out;
    logic        irq, dma_tx_req, dma_tx_wr, dma_rx_req, dma_rx_ack;
    logic [7:0]  addr;
    logic [31:0] wr_data, rd_data, dma_tx_data, dma_rx_data;
    logic [15:0] tag_seen;
    logic [19:0] slot_seen [1:4];
    int          err_count;
    int          num_checks;
    acl_controller i_acl_controller (.sys_clk(sys_clk), .resetn(resetn), .addr(addr), .wr_data(wr_data),
        .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data), .bit_clk(bit_clk), .sdata_in(sdata_in),
        .ac_sync(ac_sync), .sdata_out(sdata_out), .irq(irq), .dma_tx_req(dma_tx_req), .dma_tx_wr(dma_tx_wr),
        .dma_tx_data(dma_tx_data), .dma_rx_req(dma_rx_req), .dma_rx_ack(dma_rx_ack), .dma_rx_data(dma_rx_data));
    acl_codec_model i_acl_codec_model (.bit_clk(bit_clk), .sdata_in(sdata_in), .ac_sync(ac_sync),
        .sdata_out(sdata_out), .tag_seen(tag_seen), .slot_seen(slot_seen));
    // ==========================================
    // bus tasks and comparison
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        wr_strobe <= 1'b1;
        addr <= a;
        wr_data <= v;
        @(posedge sys_clk);
        wr_strobe <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        rd_strobe <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        rd_strobe <= 1'b0;
        #1 chk(rd_data, e);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial begin
        #800000;
        err_count++;
        $display("Error %0t: watchdog expired", $time);
        summarize();
    end
    // ==========================================
    // test sequence
    initial begin
        {resetn, wr_strobe, rd_strobe, dma_tx_wr, dma_rx_ack} = 5'h00;
        addr = 8'h00;
        wr_data = 32'h0;
        dma_tx_data = 32'h0;
        err_count = 0;
        num_checks = 0;
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        rc(`ACL_OFF_IRQ_MASK, 32'h0);
        $display("reset test done");
        wr(`ACL_OFF_MODE, 32'h1);
        wr(`ACL_OFF_IN_ASSIGN, 32'h1);
        wr(`ACL_OFF_OUT_ASSIGN, 32'h9);
        wr(`ACL_OFF_A_MODE, 32'h18);
        wr(`ACL_OFF_B_MODE, 32'h0E);
        repeat (3) @(posedge ac_sync);
        rc(`ACL_OFF_B_STAT, 32'h3);
        wr(`ACL_OFF_A_TX, 32'h000ABCDE);
        wr(`ACL_OFF_B_TX, 32'h00001234);
        wr(`ACL_OFF_COD_TX, 32'h00021234);
        repeat (2) @(posedge ac_sync);
        chk({16'h0, tag_seen}, 32'hF800);
        chk({12'h0, slot_seen[1]}, 32'h02000);
        chk({12'h0, slot_seen[2]}, 32'h12340);
        chk({12'h0, slot_seen[3]}, 32'hABCDE);
        chk({12'h0, slot_seen[4]}, 32'h03412);
        rc(`ACL_OFF_A_RX, 32'h00090003);
        rc(`ACL_OFF_A_STAT, 32'hF);
        rc(`ACL_OFF_A_STAT, 32'h3);
        rc(`ACL_OFF_COD_RX, 32'h00009000);
        chk({31'h0, dma_tx_req}, 32'h1);
        $display("transfer test done");
        @(posedge sys_clk);
        dma_tx_wr <= 1'b1;
        dma_tx_data <= 32'h00012345;
        @(posedge sys_clk);
        dma_tx_wr <= 1'b0;
        wr(`ACL_OFF_COD_TX, 32'h00820000);
        repeat (2) @(posedge ac_sync);
        chk({31'h0, tag_seen[11]}, 32'h0);
        chk({12'h0, slot_seen[1]}, 32'h82000);
        chk({12'h0, slot_seen[2]}, 32'h0);
        chk({12'h0, slot_seen[3]}, 32'h12345);
        chk(dma_rx_data, 32'h00090003);
        @(posedge sys_clk);
        dma_rx_ack <= 1'b1;
        @(posedge sys_clk);
        dma_rx_ack <= 1'b0;
        #1 chk({31'h0, dma_rx_req}, 32'h0);
        $display("dma test done");
        wr(`ACL_OFF_IRQ_EN, 32'h8);
        #1 chk({31'h0, irq}, 32'h0);
        wr(`ACL_OFF_IRQ_EN, 32'h4);
        #1 chk({31'h0, irq}, 32'h1);
        rc(`ACL_OFF_IRQ_MASK, 32'hC);
        wr(`ACL_OFF_IRQ_DIS, 32'hF);
        rc(`ACL_OFF_IRQ_MASK, 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("interrupt test done");
        summarize();
    end
endmodule
